// ==== bfl_pkg.sv ====
package bfl_pkg;

    // ------------------------------------------------------------
    // Lock field encodings (1 = unprogrammed, 0 = programmed)
    // ------------------------------------------------------------
    localparam logic [1:0] BFL_LOCK_MODE1 = 2'h3;
    localparam logic [1:0] BFL_LOCK_MODE2 = 2'h2;
    localparam logic [1:0] BFL_LOCK_MODE3 = 2'h0;
    localparam logic [1:0] BFL_LOCK_MODE4 = 2'h1;
    localparam logic [1:0] BFL_LOCK_RESET = 2'h3;

    // ------------------------------------------------------------
    // Address layout
    // ------------------------------------------------------------
    localparam int BFL_PC_WIDTH = 15;
    localparam int BFL_PAGE_WORD_BITS = 7;
    localparam int BFL_BOOT_START_DEFAULT = 16'h7000;
    localparam logic [7:0] BFL_EXT_RESET = 8'h00;
    localparam logic [23:0] BFL_APP_RESET_VECTOR = 24'h000000;

    // ------------------------------------------------------------
    // Lock write data layout
    // ------------------------------------------------------------
    localparam int BFL_LOCKDATA_APP_LO = 2;
    localparam int BFL_LOCKDATA_BOOT_LO = 4;

    // ------------------------------------------------------------
    // Operation state
    // ------------------------------------------------------------
    typedef enum logic [2:0] {
        BFL_ST_IDLE = 3'b001,
        BFL_ST_STORE = 3'b010,
        BFL_ST_LOAD = 3'b100
    } bfl_state_t;

endpackage : bfl_pkg

// ==== bfl_lock_bits.sv ====
`timescale 1ns/1ps
module bfl_lock_bits (
    // Clock and reset
    input wire logic clk_sys,
    input wire logic rst,
    // Chip erase and external programming
    input wire logic chip_erase,
    input wire logic ext_prog_we,
    input wire logic [1:0] ext_prog_data,
    // Software programming
    input wire logic sw_prog_we,
    input wire logic [1:0] sw_prog_data,
    // Current field
    output logic [1:0] lock_q
);
    import bfl_pkg::*;

    // ------------------------------------------------------------
    // Lock field
    // ------------------------------------------------------------
    // Bits only go from 1 to 0; erase alone restores them.
    // Reset does not touch the field because it models nonvolatile bits.
    logic [1:0] field_q = BFL_LOCK_RESET;

    always_ff @(posedge clk_sys) begin
        if (chip_erase) begin
            field_q <= BFL_LOCK_RESET;
        end else if (ext_prog_we) begin
            field_q <= field_q & ext_prog_data;
        end else if (sw_prog_we) begin
            field_q <= field_q & sw_prog_data;
        end
    end

    assign lock_q = field_q;

endmodule : bfl_lock_bits

// ==== bfl_addr_split.sv ====
`timescale 1ns/1ps
module bfl_addr_split #(
    parameter int PC_WIDTH = 15,
    parameter int WORD_BITS = 7
) (
    // Byte address from pointer
    input wire logic [23:0] byte_addr,
    // Split result
    output logic [PC_WIDTH-1:0] word_addr,
    output logic [PC_WIDTH-WORD_BITS-1:0] page_addr,
    output logic [WORD_BITS-1:0] word_in_page,
    output logic byte_sel
);
    assign word_addr = byte_addr[PC_WIDTH:1];
    assign page_addr = byte_addr[PC_WIDTH:WORD_BITS+1];
    assign word_in_page = byte_addr[WORD_BITS:1];
    assign byte_sel = byte_addr[0];
endmodule : bfl_addr_split

// ==== bfl_boot_flash_lock.sv ====
`timescale 1ns/1ps
// How it works
// - Application and boot lock fields are separate and change independently.
// - Software or programmer may clear lock bits; only chip erase sets them.
// - General write lock never blocks program-memory stores.
// - General read/write lock never blocks program-memory loads or stores.
// - Application mode 1 leaves application stores and loads unrestricted.
// - Application mode 2 blocks stores to application, loads still allowed.
// - Application mode 3 blocks stores and boot-code loads of application.
// - Application mode 4 allows stores, blocks boot-code loads of application.
// - App modes 3, 4 with boot vectors mask interrupts in application.
// - Boot mode 1 leaves boot section stores and loads unrestricted.
// - Boot mode 2 blocks stores into the boot section.
// - Boot mode 3 blocks stores and application-code loads of boot.
// - Boot mode 4 allows stores, blocks application-code loads of boot.
// - Boot modes 3, 4 with application vectors mask interrupts in boot.
// - Unprogrammed boot-reset fuse starts execution at word zero.
// - Programmed boot-reset fuse starts execution at boot section start.
// - Fuses change only through the external programming port.
// - Address is pointer bytes plus optional upper extension byte.
// - Low address bits select word in page, high bits select page.
// - Stores latch their own page address along with word and offset.
// - Store target address and load byte select are latched when an operation starts.
// - Loads address bytes; pointer bit zero picks low or high byte.
// - Stores issued from application code are ignored.
module bfl_boot_flash_lock #(
    parameter int PC_WIDTH = bfl_pkg::BFL_PC_WIDTH,
    parameter int WORD_BITS = bfl_pkg::BFL_PAGE_WORD_BITS,
    parameter bit HAS_EXT_BYTE = 1'b0,
    parameter logic [PC_WIDTH-1:0] BOOT_START =
        PC_WIDTH'(bfl_pkg::BFL_BOOT_START_DEFAULT)
) (
    // Clock and reset
    input wire logic clk_sys,
    input wire logic rst,
    // External programming port
    input wire logic chip_erase,
    input wire logic ext_lock_we,
    input wire logic [1:0] ext_app_lock,
    input wire logic [1:0] ext_boot_lock,
    input wire logic ext_fuse_we,
    input wire logic ext_fuse_val,
    // Core status
    input wire logic [PC_WIDTH-1:0] exec_pc,
    input wire logic vectors_in_boot,
    input wire logic irq_enable_core,
    // Pointer registers
    input wire logic [7:0] pointer_low_byte,
    input wire logic [7:0] pointer_high_byte,
    input wire logic ext_byte_we,
    input wire logic [7:0] ext_byte_wdata,
    // Store and load requests
    input wire logic store_req,
    input wire logic store_is_lock_set,
    input wire logic [7:0] store_lock_data,
    input wire logic load_req,
    // Flash side
    input wire logic [15:0] flash_rdata,
    output logic flash_store_go,
    output logic [PC_WIDTH-1:0] flash_store_word,
    output logic [PC_WIDTH-WORD_BITS-1:0] flash_store_page,
    output logic [WORD_BITS-1:0] flash_store_offset,
    // Results
    output logic [7:0] load_data,
    output logic load_valid,
    output logic access_blocked,
    output logic irq_allowed,
    output logic [PC_WIDTH-1:0] reset_vector,
    output logic [7:0] extended_pointer_page_byte,
    output logic [1:0] app_lock_q,
    output logic [1:0] boot_lock_q
);
    import bfl_pkg::*;

    // ------------------------------------------------------------
    // Decode helpers
    // ------------------------------------------------------------
    function automatic logic in_boot(input logic [PC_WIDTH-1:0] a);
        in_boot = (a >= BOOT_START);
    endfunction : in_boot

    function automatic logic store_locked(input logic [1:0] m);
        store_locked = (m == BFL_LOCK_MODE2) || (m == BFL_LOCK_MODE3);
    endfunction : store_locked

    function automatic logic load_locked(input logic [1:0] m);
        load_locked = (m == BFL_LOCK_MODE3) || (m == BFL_LOCK_MODE4);
    endfunction : load_locked

    // ------------------------------------------------------------
    // Lock fields and fuse
    // ------------------------------------------------------------
    logic sw_lock_we;
    logic [1:0] app_lock;
    logic [1:0] boot_lock;
    logic boot_reset_select_fuse = 1'b1;
    logic [PC_WIDTH-1:0] reset_vec_d;

    bfl_lock_bits u_app_lock (
        .clk_sys(clk_sys),
        .rst(rst),
        .chip_erase(chip_erase),
        .ext_prog_we(ext_lock_we),
        .ext_prog_data(ext_app_lock),
        .sw_prog_we(sw_lock_we),
        .sw_prog_data(store_lock_data[BFL_LOCKDATA_APP_LO +: 2]),
        .lock_q(app_lock)
    );

    bfl_lock_bits u_boot_lock (
        .clk_sys(clk_sys),
        .rst(rst),
        .chip_erase(chip_erase),
        .ext_prog_we(ext_lock_we),
        .ext_prog_data(ext_boot_lock),
        .sw_prog_we(sw_lock_we),
        .sw_prog_data(store_lock_data[BFL_LOCKDATA_BOOT_LO +: 2]),
        .lock_q(boot_lock)
    );

    always_ff @(posedge clk_sys) begin
        if (ext_fuse_we) begin
            boot_reset_select_fuse <= ext_fuse_val;
        end
    end

    // The fuse powers up unprogrammed and reset never touches it,
    // because it stands for a nonvolatile cell.

    assign reset_vec_d = boot_reset_select_fuse ?
        BFL_APP_RESET_VECTOR[PC_WIDTH-1:0] : BOOT_START;

    always_ff @(posedge clk_sys) begin
        reset_vector <= reset_vec_d;
        app_lock_q <= app_lock;
        boot_lock_q <= boot_lock;
    end

    // ------------------------------------------------------------
    // Address formation
    // ------------------------------------------------------------
    logic [7:0] ext_byte;
    logic [23:0] ptr_addr;
    logic [PC_WIDTH-1:0] tgt_word;
    logic [PC_WIDTH-WORD_BITS-1:0] tgt_page;
    logic [WORD_BITS-1:0] tgt_offset;
    logic tgt_byte_sel;

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            extended_pointer_page_byte <= BFL_EXT_RESET;
        end else if (ext_byte_we && HAS_EXT_BYTE) begin
            extended_pointer_page_byte <= ext_byte_wdata;
        end
    end

    assign ext_byte = HAS_EXT_BYTE ? extended_pointer_page_byte : 8'h00;
    assign ptr_addr = {ext_byte, pointer_high_byte, pointer_low_byte};

    bfl_addr_split #(
        .PC_WIDTH(PC_WIDTH),
        .WORD_BITS(WORD_BITS)
    ) u_split (
        .byte_addr(ptr_addr),
        .word_addr(tgt_word),
        .page_addr(tgt_page),
        .word_in_page(tgt_offset),
        .byte_sel(tgt_byte_sel)
    );

    // ------------------------------------------------------------
    // Access checks
    // ------------------------------------------------------------
    logic exec_boot;
    logic tgt_boot;
    logic store_ok;
    logic load_ok;
    logic [1:0] tgt_lock;
    // Declared here because the lock-set strobe needs the idle test.
    bfl_state_t state_q;

    assign exec_boot = in_boot(exec_pc);
    assign tgt_boot = in_boot(tgt_word);
    assign tgt_lock = tgt_boot ? boot_lock : app_lock;

    assign store_ok = exec_boot && !store_locked(tgt_lock);
    assign load_ok = (exec_boot == tgt_boot) || !load_locked(tgt_lock);
    assign sw_lock_we = store_req && store_is_lock_set && exec_boot &&
        (state_q == BFL_ST_IDLE);

    // ------------------------------------------------------------
    // Operation sequencing
    // ------------------------------------------------------------
    logic load_sel_q;

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            state_q <= BFL_ST_IDLE;
        end else begin
            case (state_q)
                BFL_ST_IDLE: begin
                    if (store_req && !store_is_lock_set && store_ok) begin
                        state_q <= BFL_ST_STORE;
                    end else if (load_req && load_ok) begin
                        state_q <= BFL_ST_LOAD;
                    end
                end
                default: begin
                    state_q <= BFL_ST_IDLE;
                end
            endcase
        end
    end

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            flash_store_go <= 1'b0;
            flash_store_word <= '0;
            flash_store_page <= '0;
            flash_store_offset <= '0;
        end else begin
            flash_store_go <= 1'b0;
            if (state_q == BFL_ST_IDLE && store_req && !store_is_lock_set &&
                store_ok) begin
                flash_store_go <= 1'b1;
                flash_store_word <= tgt_word;
                flash_store_page <= tgt_page;
                flash_store_offset <= tgt_offset;
            end
        end
    end

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            load_sel_q <= 1'b0;
        end else if (state_q == BFL_ST_IDLE && load_req) begin
            load_sel_q <= tgt_byte_sel;
        end
    end

    // The flash answers one cycle after the load is taken.
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            load_valid <= 1'b0;
            load_data <= 8'h00;
        end else begin
            load_valid <= (state_q == BFL_ST_LOAD);
            if (state_q == BFL_ST_LOAD) begin
                load_data <= load_sel_q ? flash_rdata[15:8] : flash_rdata[7:0];
            end
        end
    end

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            access_blocked <= 1'b0;
        end else begin
            access_blocked <= (state_q == BFL_ST_IDLE) &&
                ((store_req && !store_is_lock_set && !store_ok) ||
                 (!store_req && load_req && !load_ok));
        end
    end

    // ------------------------------------------------------------
    // Interrupt gating
    // ------------------------------------------------------------
    // app and boot section masks
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            irq_allowed <= 1'b0;
        end else begin
            irq_allowed <= irq_enable_core &&
                !(vectors_in_boot && !exec_boot && load_locked(app_lock)) &&
                !(!vectors_in_boot && exec_boot && load_locked(boot_lock));
        end
    end

endmodule : bfl_boot_flash_lock

// ==== bfl_boot_flash_lock_monitor.sv ====
`timescale 1ns/1ps
// ------------------------------------------------------------
// Checker
// ------------------------------------------------------------
module bfl_chk #(
    parameter int PC_WIDTH = 15,
    parameter int WORD_BITS = 7,
    parameter logic [PC_WIDTH-1:0] BOOT_START = 15'h7000
) (
    // Clock and reset
    input wire logic clk_sys,
    input wire logic rst,
    // Core and erase inputs
    input wire logic chip_erase,
    input wire logic [PC_WIDTH-1:0] exec_pc,
    input wire logic vectors_in_boot,
    input wire logic irq_enable_core,
    input wire logic [7:0] pointer_low_byte,
    input wire logic [7:0] pointer_high_byte,
    input wire logic store_req,
    input wire logic load_req,
    // Results
    input wire logic flash_store_go,
    input wire logic [PC_WIDTH-1:0] flash_store_word,
    input wire logic [PC_WIDTH-WORD_BITS-1:0] flash_store_page,
    input wire logic [WORD_BITS-1:0] flash_store_offset,
    input wire logic load_valid,
    input wire logic access_blocked,
    input wire logic irq_allowed,
    input wire logic [PC_WIDTH-1:0] reset_vector,
    input wire logic [1:0] app_lock_q,
    input wire logic [1:0] boot_lock_q
);
    logic [15:0] zp;
    logic bx, ta, am, bm, wa, wb;
    assign zp = {pointer_high_byte, pointer_low_byte};
    assign bx = exec_pc >= BOOT_START;
    assign ta = (zp >> 1) < BOOT_START;
    assign wa = ta && !app_lock_q[0];
    assign wb = !ta && !boot_lock_q[0];
    // Erase is excluded because the copies lag the fields.
    assign am = !bx && vectors_in_boot && !app_lock_q[1] && !chip_erase;
    assign bm = bx && !vectors_in_boot && !boot_lock_q[1] && !chip_erase;
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (rst);
    a_store_boot: assert property (
        flash_store_go |-> $past(store_req) && $past(bx))
        else $error("store issued without boot code");
    a_store_addr: assert property (
        flash_store_go |-> flash_store_word == PC_WIDTH'($past(zp) >> 1))
        else $error("store word address wrong");
    a_page_split: assert property (
        flash_store_go |->
        {flash_store_page, flash_store_offset} == flash_store_word)
        else $error("page and offset split wrong");
    a_app_wlock: assert property (
        flash_store_go |-> !$past(wa)) else $error("app store not locked");
    a_boot_wlock: assert property (
        flash_store_go |-> !$past(wb)) else $error("boot store not locked");
    a_load_lat: assert property (
        load_valid |-> $past(load_req, 2)) else $error("load latency wrong");
    a_blk_quiet: assert property (
        access_blocked |-> !flash_store_go ##1 !load_valid)
        else $error("blocked access went ahead");
    a_app_irq: assert property (
        am [*3] |-> !irq_allowed) else $error("irq not masked in app");
    a_boot_irq: assert property (
        bm [*3] |-> !irq_allowed) else $error("irq not masked in boot");
    a_irq_gate: assert property (
        irq_allowed |-> $past(irq_enable_core)) else $error("irq ungated");
    a_vec_vals: assert property (
        reset_vector == '0 || reset_vector == BOOT_START)
        else $error("reset vector value wrong");
    a_lock_mono: assert property (
        (!chip_erase) [*3] |-> (app_lock_q & ~$past(app_lock_q)) == 2'h0
        && (boot_lock_q & ~$past(boot_lock_q)) == 2'h0)
        else $error("lock bit returned without erase");
    c_store: cover property (flash_store_go);
    c_load: cover property (load_valid);
    c_block: cover property (access_blocked);
endmodule : bfl_chk

bind bfl_boot_flash_lock bfl_chk #(.PC_WIDTH(PC_WIDTH),
    .WORD_BITS(WORD_BITS), .BOOT_START(BOOT_START)) u_chk (
    .clk_sys(clk_sys), .rst(rst), .chip_erase(chip_erase),
    .exec_pc(exec_pc), .vectors_in_boot(vectors_in_boot),
    .irq_enable_core(irq_enable_core),
    .pointer_low_byte(pointer_low_byte),
    .pointer_high_byte(pointer_high_byte),
    .store_req(store_req), .load_req(load_req),
    .flash_store_go(flash_store_go), .flash_store_word(flash_store_word),
    .flash_store_page(flash_store_page),
    .flash_store_offset(flash_store_offset), .load_valid(load_valid),
    .access_blocked(access_blocked), .irq_allowed(irq_allowed),
    .reset_vector(reset_vector), .app_lock_q(app_lock_q),
    .boot_lock_q(boot_lock_q));

// ==== bfl_flash_model.sv ====
`timescale 1ns/1ps
// ------------------------------------------------------------
// Flash array model
// ------------------------------------------------------------
module bfl_flash_model (
    // Clock
    input wire logic clk_sys,
    // Core side
    input wire logic [7:0] pointer_low_byte,
    input wire logic [7:0] pointer_high_byte,
    input wire logic load_req,
    input wire logic flash_store_go,
    // Flash side
    output logic [15:0] flash_rdata,
    output int n_writes
);
    logic ld_q = 1'h0;
    logic [15:0] junk_q = 16'h0;
    logic [14:0] w;
    assign w = {pointer_high_byte, pointer_low_byte[7:1]};
    // Word data is good only in the read cycle; junk elsewhere.
    always_ff @(posedge clk_sys) begin
        ld_q <= load_req;
        junk_q <= ~junk_q + 16'h1357;
    end
    assign flash_rdata = ld_q ? {w[14:7] ^ 8'hA5, w[7:0] ^ 8'h3C} : junk_q;
    int wr_cnt_q = 0;
    always_ff @(posedge clk_sys) begin
        if (flash_store_go) begin
            wr_cnt_q <= wr_cnt_q + 1;
        end
    end
    assign n_writes = wr_cnt_q;
endmodule : bfl_flash_model

// ==== bfl_boot_flash_lock_tb_top.sv ====
`timescale 1ns/1ps
// ------------------------------------------------------------
// Testbench
// ------------------------------------------------------------
module bfl_boot_flash_lock_tb_top;
    import bfl_pkg::*;
    localparam logic [14:0] BS = 15'h7000;
    logic clk_sys = 1'h0, rst = 1'h1, chip_erase = 1'h0, ext_lock_we = 1'h0;
    logic [1:0] ext_app_lock = 2'h3, ext_boot_lock = 2'h3, al = 2'h3;
    logic [1:0] bl = 2'h3, md [4];
    logic ext_fuse_we = 1'h0, ext_fuse_val = 1'h1, vectors_in_boot = 1'h0;
    logic [14:0] exec_pc = 15'h0;
    logic [7:0] pointer_low_byte = 8'h0, pointer_high_byte = 8'h0;
    logic irq_enable_core = 1'h0, ext_byte_we = 1'h0, store_req = 1'h0;
    logic [7:0] ext_byte_wdata = 8'h0, store_lock_data = 8'h0;
    logic store_is_lock_set = 1'h0, load_req = 1'h0;
    logic [15:0] flash_rdata;
    logic flash_store_go, load_valid, access_blocked, irq_allowed;
    logic [14:0] flash_store_word, reset_vector;
    logic [7:0] flash_store_page, load_data, extended_pointer_page_byte;
    logic [6:0] flash_store_offset;
    logic [1:0] app_lock_q, boot_lock_q;
    int n_errors = 0, total_checks = 0, nw = 0, n_writes, seed = 2013;
    always #50 clk_sys = ~clk_sys;
    bfl_boot_flash_lock #(.HAS_EXT_BYTE(1'b0)) dut (.clk_sys(clk_sys),
        .rst(rst), .chip_erase(chip_erase), .ext_lock_we(ext_lock_we),
        .ext_app_lock(ext_app_lock), .ext_boot_lock(ext_boot_lock),
        .ext_fuse_we(ext_fuse_we), .ext_fuse_val(ext_fuse_val),
        .exec_pc(exec_pc), .vectors_in_boot(vectors_in_boot),
        .irq_enable_core(irq_enable_core), .pointer_low_byte(pointer_low_byte),
        .pointer_high_byte(pointer_high_byte), .ext_byte_we(ext_byte_we),
        .ext_byte_wdata(ext_byte_wdata), .store_req(store_req),
        .store_is_lock_set(store_is_lock_set),
        .store_lock_data(store_lock_data), .load_req(load_req),
        .flash_rdata(flash_rdata), .flash_store_go(flash_store_go),
        .flash_store_word(flash_store_word),
        .flash_store_page(flash_store_page),
        .flash_store_offset(flash_store_offset), .load_data(load_data),
        .load_valid(load_valid), .access_blocked(access_blocked),
        .irq_allowed(irq_allowed), .reset_vector(reset_vector),
        .extended_pointer_page_byte(extended_pointer_page_byte),
        .app_lock_q(app_lock_q), .boot_lock_q(boot_lock_q));
    bfl_flash_model u_flash (.clk_sys(clk_sys),
        .pointer_low_byte(pointer_low_byte),
        .pointer_high_byte(pointer_high_byte), .load_req(load_req),
        .flash_store_go(flash_store_go), .flash_rdata(flash_rdata),
        .n_writes(n_writes));
    task automatic chk(input string nm, input logic [31:0] s, e);
        total_checks++;
        if (s !== e) begin
            n_errors++;
            $display("[ERR] %s exp %h seen %h", nm, e, s);
        end
    endtask : chk
    task automatic tk(input int n);
        repeat (n) @(posedge clk_sys);
        #1;
    endtask : tk
    task automatic complete_run;
        if (n_errors == 0 && total_checks > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask : complete_run
    // At least half the picks land in the boot section on purpose.
    task automatic rnd;
        logic [31:0] r;
        r = $random(seed);
        {vectors_in_boot, irq_enable_core, exec_pc} = r[16:0];
        if (r[17]) exec_pc[14:12] = 3'h7;
        {pointer_high_byte, pointer_low_byte} = r[31:16];
        if (r[18]) pointer_high_byte[7:5] = 3'h7;
    endtask : rnd
    task automatic do_store(input logic lk, input logic [7:0] d);
        logic [14:0] tw;
        logic ok;
        logic bt;
        tw = {pointer_high_byte, pointer_low_byte[7:1]};
        bt = exec_pc >= BS;
        ok = bt && !lk && (tw < BS ? al[0] : bl[0]);
        store_req = 1'h1;
        store_is_lock_set = lk;
        store_lock_data = d;
        tk(1);
        store_req = 1'h0;
        rnd();
        if (!lk) begin
            chk("go", flash_store_go, ok);
            chk("blk", access_blocked, !ok);
            if (ok) chk("word", flash_store_word, tw);
            if (ok) chk("page", flash_store_page, tw[14:7]);
            if (ok) chk("offs", flash_store_offset, tw[6:0]);
        end
        if (ok) nw++;
        if (lk && bt) begin
            al &= d[3:2];
            bl &= d[5:4];
        end
        tk(2);
    endtask : do_store
    task automatic do_load;
        logic [14:0] tw;
        logic ok;
        logic [7:0] e;
        tw = {pointer_high_byte, pointer_low_byte[7:1]};
        ok = tw < BS ? !(exec_pc >= BS && !al[1]) : !(exec_pc < BS && !bl[1]);
        e = pointer_low_byte[0] ? tw[14:7] ^ 8'hA5 : tw[7:0] ^ 8'h3C;
        load_req = 1'h1;
        tk(1);
        load_req = 1'h0;
        chk("lblk", access_blocked, !ok);
        tk(1);
        chk("lvld", load_valid, ok);
        if (ok) chk("ldat", load_data, e);
        tk(1);
    endtask : do_load
    task automatic set_lock(input logic [1:0] a, b);
        ext_app_lock = a;
        ext_boot_lock = b;
        ext_lock_we = 1'h1;
        tk(1);
        ext_lock_we = 1'h0;
        al &= a;
        bl &= b;
        tk(2);
        chk("app", app_lock_q, al);
        chk("boot", boot_lock_q, bl);
    endtask : set_lock
    initial begin
        #2000000;
        n_errors++;
        complete_run();
    end
    initial begin
        md = '{BFL_LOCK_MODE1, BFL_LOCK_MODE2, BFL_LOCK_MODE3, BFL_LOCK_MODE4};
        tk(3);
        rst = 1'h0;
        ext_byte_we = 1'h1;
        ext_byte_wdata = 8'h5A;
        tk(1);
        ext_byte_we = 1'h0;
        tk(2);
        chk("vec", reset_vector, 15'h0);
        chk("ext", extended_pointer_page_byte, 8'h0);
        for (int f = 0; f < 2; f++) begin
            ext_fuse_val = f[0];
            ext_fuse_we = 1'h1;
            tk(1);
            ext_fuse_we = 1'h0;
            tk(2);
            chk("vec", reset_vector, f ? 15'h0 : BS);
        end
        exec_pc = BS;
        do_store(1'h1, 8'hDB);
        set_lock(2'h3, 2'h3);
        exec_pc = 15'h0;
        do_store(1'h1, 8'h00);
        set_lock(2'h3, 2'h3);
        for (int i = 0; i < 64; i++) begin
            chip_erase = 1'h1;
            tk(1);
            chip_erase = 1'h0;
            al = 2'h3;
            bl = 2'h3;
            set_lock(md[i % 4], md[(i / 4) % 4]);
            rnd();
            tk(2);
            chk("irq", irq_allowed, irq_enable_core
                && !(exec_pc < BS && vectors_in_boot && !al[1])
                && !(exec_pc >= BS && !vectors_in_boot && !bl[1]));
            do_store(1'h0, 8'h0);
            do_load();
        end
        chk("nwr", n_writes, nw);
        complete_run();
    end
endmodule : bfl_boot_flash_lock_tb_top
